// >>> shared/eagen_regs.svh
// timing-free constants for the effective address generator
// assumes inclusion from the design file only
`ifndef EAGEN_REGS_SVH
`define EAGEN_REGS_SVH
`define EAGEN_LEN_IX 16'h0001
`define EAGEN_LEN_TWO 16'h0002
`define EAGEN_LEN_THREE 16'h0003
`define EAGEN_ZERO_PAGE 8'h00
`define EAGEN_CTR_RESET 16'h0000
`endif

// >>> shared/eagen_pkg.sv
// types for the effective address generator
// assumes the constants header is on the include path
`default_nettype none
package eagen_pkg;
    typedef enum logic [3:0] {
        MODE_INH = 4'h0,
        MODE_IMM = 4'h1,
        MODE_DIR = 4'h2,
        MODE_EXT = 4'h3,
        MODE_IX = 4'h4,
        MODE_IX1 = 4'h5,
        MODE_IX2 = 4'h6,
        MODE_REL = 4'h7,
        MODE_BSC = 4'h8,
        MODE_BTB = 4'h9
    } eagen_mode_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] byte1;
        logic [7:0] byte2;
        logic [7:0] index;
        logic [15:0] program_counter;
    } eagen_req_t;

    typedef struct packed {
        logic [7:0] addr_high;
        logic [7:0] addr_low;
        logic [15:0] next_pc;
        logic [2:0] bit_select;
    } eagen_resp_t;
endpackage
`default_nettype wire

// >>> hdl/eagen_core.sv
// effective address and next program counter generator
// assumes the core presents opcode, operand bytes, index and counter with a strobe
// What this block does
// - direct: high zero, low operand, counter plus two
// - extended: two operand bytes, counter plus three
// - indexed no offset: index low, counter plus one
// - eight bit offset: sum low, carry high
// - index register never modified
// - sixteen bit offset: carry into high byte
// - relative: signed offset added only when taken
// - relative branch target spans minus 126 to plus 129
// - bit set/clear: direct address, opcode bit field
// - bit test: opcode nibble bit, direct byte
// - bit test taken: counter plus three plus offset
// - immediate: operand at counter plus one
`timescale 1ns/1ps
`default_nettype none
`include "eagen_regs.svh"
module eagen_core (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic req_valid,
    input wire eagen_pkg::eagen_mode_t mode,
    input wire eagen_pkg::eagen_req_t req,
    input wire logic branch_cond,
    output logic resp_valid,
    output eagen_pkg::eagen_resp_t resp
);
    logic rst_meta_ff;
    logic rst_sync_ff;
    logic resp_valid_ff;
    eagen_pkg::eagen_resp_t resp_ff;
    eagen_pkg::eagen_resp_t nxt_resp;
    logic [8:0] low_sum;
    logic [15:0] rel_off;
    logic [15:0] ctr_plus2;
    logic [15:0] ctr_plus3;

    // branch offset byte sign extended to counter width
    function automatic logic [15:0] sext_offset(input logic [7:0] offset);
        return {{8{offset[7]}}, offset};
    endfunction

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // operands only read, index is never written back
    assign low_sum = {1'b0, req.index}
                     + {1'b0, (mode == eagen_pkg::MODE_IX2) ? req.byte2 : req.byte1};
    assign ctr_plus2 = req.program_counter + `EAGEN_LEN_TWO;
    assign ctr_plus3 = req.program_counter + `EAGEN_LEN_THREE;
    assign rel_off = sext_offset((mode == eagen_pkg::MODE_BTB) ? req.byte2 : req.byte1);

    always_comb begin
        nxt_resp.addr_high = `EAGEN_ZERO_PAGE;
        nxt_resp.addr_low = req.byte1;
        nxt_resp.next_pc = req.program_counter + `EAGEN_LEN_IX;
        nxt_resp.bit_select = 3'h0;
        unique case (mode)
            eagen_pkg::MODE_INH: begin
                nxt_resp.addr_low = `EAGEN_ZERO_PAGE;
            end
            eagen_pkg::MODE_IMM: begin
                {nxt_resp.addr_high, nxt_resp.addr_low} = req.program_counter + `EAGEN_LEN_IX;
                nxt_resp.next_pc = ctr_plus2;
            end
            eagen_pkg::MODE_DIR: begin
                nxt_resp.next_pc = ctr_plus2;
            end
            eagen_pkg::MODE_EXT: begin
                nxt_resp.addr_high = req.byte1;
                nxt_resp.addr_low = req.byte2;
                nxt_resp.next_pc = ctr_plus3;
            end
            eagen_pkg::MODE_IX: begin
                nxt_resp.addr_low = req.index;
            end
            eagen_pkg::MODE_IX1: begin
                nxt_resp.addr_high = {7'h00, low_sum[8]};
                nxt_resp.addr_low = low_sum[7:0];
                nxt_resp.next_pc = ctr_plus2;
            end
            eagen_pkg::MODE_IX2: begin
                nxt_resp.addr_high = req.byte1 + {7'h00, low_sum[8]};
                nxt_resp.addr_low = low_sum[7:0];
                nxt_resp.next_pc = ctr_plus3;
            end
            eagen_pkg::MODE_REL: begin
                nxt_resp.next_pc = branch_cond ? ctr_plus2 + rel_off : ctr_plus2;
            end
            eagen_pkg::MODE_BSC: begin
                nxt_resp.bit_select = req.opcode[3:1];
                nxt_resp.next_pc = ctr_plus2;
            end
            eagen_pkg::MODE_BTB: begin
                nxt_resp.bit_select = req.opcode[3:1];
                nxt_resp.next_pc = branch_cond ? ctr_plus3 + rel_off : ctr_plus3;
            end
            default: begin
                nxt_resp.next_pc = req.program_counter + `EAGEN_LEN_IX;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            resp_valid_ff <= 1'b0;
        end else begin
            resp_valid_ff <= req_valid;
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            resp_ff <= '0;
        end else if (req_valid) begin
            resp_ff <= nxt_resp;
        end
    end

    assign resp_valid = resp_valid_ff;
    assign resp = resp_ff;

    property p_direct;
        @(posedge mclk) disable iff (!rst_sync_ff)
        req_valid && mode == eagen_pkg::MODE_DIR |=> resp.addr_high == 8'h00
            && resp.addr_low == $past(req.byte1) && resp.next_pc == $past(req.program_counter) + 16'h0002;
    endproperty
    a_direct: assert property (p_direct) else $error("direct address wrong");

    property p_ext;
        @(posedge mclk) disable iff (!rst_sync_ff)
        req_valid && mode == eagen_pkg::MODE_EXT |=> {resp.addr_high, resp.addr_low} == $past({req.byte1, req.byte2})
            && resp.next_pc == $past(req.program_counter) + 16'h0003;
    endproperty
    a_ext: assert property (p_ext) else $error("extended address wrong");

    property p_ix;
        @(posedge mclk) disable iff (!rst_sync_ff)
        req_valid && mode == eagen_pkg::MODE_IX |=> {resp.addr_high, resp.addr_low} == {8'h00, $past(req.index)}
            && resp.next_pc == $past(req.program_counter) + 16'h0001;
    endproperty
    a_ix: assert property (p_ix) else $error("indexed address wrong");

    property p_ix1;
        @(posedge mclk) disable iff (!rst_sync_ff)
        req_valid && mode == eagen_pkg::MODE_IX1 |=>
            {resp.addr_high, resp.addr_low} == 16'($past(req.index)) + 16'($past(req.byte1));
    endproperty
    a_ix1: assert property (p_ix1) else $error("offset indexed address wrong");

    property p_ix2;
        @(posedge mclk) disable iff (!rst_sync_ff)
        req_valid && mode == eagen_pkg::MODE_IX2 |=> {resp.addr_high, resp.addr_low}
            == 16'($past({req.byte1, req.byte2}) + 16'($past(req.index)));
    endproperty
    a_ix2: assert property (p_ix2) else $error("long indexed address wrong");

    property p_rel;
        @(posedge mclk) disable iff (!rst_sync_ff)
        req_valid && mode == eagen_pkg::MODE_REL && !branch_cond |=>
            resp.next_pc == $past(req.program_counter) + 16'h0002;
    endproperty
    a_rel: assert property (p_rel) else $error("untaken branch counter wrong");

    property p_span;
        @(posedge mclk) disable iff (!rst_sync_ff)
        req_valid && mode == eagen_pkg::MODE_REL && branch_cond |=>
            16'(resp.next_pc - $past(req.program_counter) + 16'h007E) <= 16'h00FF;
    endproperty
    a_span: assert property (p_span) else $error("branch span out of range");

    property p_btb;
        @(posedge mclk) disable iff (!rst_sync_ff)
        req_valid && mode == eagen_pkg::MODE_BTB |=> resp.addr_high == 8'h00
            && resp.bit_select == $past(req.opcode[3:1]) && resp_valid;
    endproperty
    a_btb: assert property (p_btb) else $error("bit test address wrong");

    property p_imm;
        @(posedge mclk) disable iff (!rst_sync_ff)
        req_valid && mode == eagen_pkg::MODE_IMM |=> resp.next_pc == $past(req.program_counter) + 16'h0002
            && {resp.addr_high, resp.addr_low} == $past(req.program_counter) + 16'h0001;
    endproperty
    a_imm: assert property (p_imm) else $error("immediate operand address wrong");

    property p_bsc;
        @(posedge mclk) disable iff (!rst_sync_ff)
        req_valid && mode == eagen_pkg::MODE_BSC |=> resp.addr_high == 8'h00 && resp.addr_low == $past(req.byte1)
            && resp.bit_select == $past(req.opcode[3:1]) && resp.next_pc == $past(req.program_counter) + 16'h0002;
    endproperty
    a_bsc: assert property (p_bsc) else $error("bit set clear address wrong");

    property p_rel_taken;
        @(posedge mclk) disable iff (!rst_sync_ff)
        req_valid && mode == eagen_pkg::MODE_REL && branch_cond |=> resp.next_pc
            == $past(req.program_counter) + 16'h0002 + {{8{$past(req.byte1[7])}}, $past(req.byte1)};
    endproperty
    a_rel_taken: assert property (p_rel_taken) else $error("taken branch target wrong");

    property p_btb_pc;
        @(posedge mclk) disable iff (!rst_sync_ff)
        req_valid && mode == eagen_pkg::MODE_BTB |=> resp.next_pc == $past(req.program_counter) + 16'h0003
            + ($past(branch_cond) ? {{8{$past(req.byte2[7])}}, $past(req.byte2)} : 16'h0000);
    endproperty
    a_btb_pc: assert property (p_btb_pc) else $error("bit test branch target wrong");

    property p_ix_len;
        @(posedge mclk) disable iff (!rst_sync_ff)
        req_valid && (mode == eagen_pkg::MODE_IX1 || mode == eagen_pkg::MODE_IX2) |=> resp.next_pc
            == $past(req.program_counter) + (($past(mode) == eagen_pkg::MODE_IX2) ? 16'h0003 : 16'h0002);
    endproperty
    a_ix_len: assert property (p_ix_len) else $error("offset indexed length wrong");
endmodule // eagen_core
`default_nettype wire

// >>> verif/eagen_mem_model.sv
// program memory model on the core address bus
// assumes the bench loads bytes a cycle before presenting the fetch address
`timescale 1ns/1ps
`default_nettype none
module eagen_mem_model (
    input wire logic mclk,
    input wire logic wr_en,
    input wire logic [15:0] wr_addr,
    input wire logic [23:0] wr_data,
    input wire logic [15:0] fetch_addr,
    output logic [23:0] fetch_bytes
);
    logic [7:0] mem [0:65535];
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data[23:16];
            mem[wr_addr + 16'h0001] <= wr_data[15:8];
            mem[wr_addr + 16'h0002] <= wr_data[7:0];
        end
    end
    // operand fetch wraps at the top of memory
    assign fetch_bytes = {mem[fetch_addr], mem[fetch_addr + 16'h0001], mem[fetch_addr + 16'h0002]};
endmodule // eagen_mem_model
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the address generator
// assumes the memory model supplies opcode and operand bytes at the counter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk = 1'b0;
    logic resetn, req_valid, branch_cond, wr_en, resp_valid, pend = 1'b0;
    logic [15:0] ctr_r, wr_addr;
    logic [7:0] idx_r;
    logic [23:0] wr_data, fb;
    logic [3:0] exp_m;
    eagen_pkg::eagen_mode_t mode;
    eagen_pkg::eagen_req_t req;
    eagen_pkg::eagen_resp_t resp, exp_r;
    int failures = 0;
    int total_checks = 0;
    int unsigned seed;
    assign req = {fb, idx_r, ctr_r};
    always #20 mclk = ~mclk;
    eagen_mem_model i_mem (.mclk(mclk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .fetch_addr(ctr_r), .fetch_bytes(fb));
    eagen_core i_dut (.mclk(mclk), .resetn(resetn), .req_valid(req_valid), .mode(mode), .req(req),
        .branch_cond(branch_cond), .resp_valid(resp_valid), .resp(resp));
    function automatic eagen_pkg::eagen_resp_t f_exp(input logic [3:0] m, input eagen_pkg::eagen_req_t r,
        input logic c);
        logic [15:0] addr_exp, len, off;
        addr_exp = 16'h0000;
        len = 16'h0002;
        off = 16'h0000;
        case (m)
            eagen_pkg::MODE_INH: len = 16'h0001;
            eagen_pkg::MODE_IMM: addr_exp = r.program_counter + 16'h0001;
            eagen_pkg::MODE_DIR, eagen_pkg::MODE_BSC: addr_exp = {8'h00, r.byte1};
            eagen_pkg::MODE_EXT: begin
                addr_exp = {r.byte1, r.byte2};
                len = 16'h0003;
            end
            eagen_pkg::MODE_IX: begin
                addr_exp = {8'h00, r.index};
                len = 16'h0001;
            end
            eagen_pkg::MODE_IX1: addr_exp = {8'h00, r.index} + {8'h00, r.byte1};
            eagen_pkg::MODE_IX2: begin
                addr_exp = {r.byte1, r.byte2} + {8'h00, r.index};
                len = 16'h0003;
            end
            eagen_pkg::MODE_REL: off = c ? {{8{r.byte1[7]}}, r.byte1} : 16'h0000;
            default: begin
                addr_exp = {8'h00, r.byte1};
                len = 16'h0003;
                off = c ? {{8{r.byte2[7]}}, r.byte2} : 16'h0000;
            end
        endcase
        return {addr_exp, r.program_counter + len + off, r.opcode[3:1]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (failures == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic load(input logic [15:0] a, input logic [23:0] d);
        req_valid = 1'b0;
        wr_en = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(posedge mclk) #1;
    endtask
    task automatic issue(input logic [3:0] m, input logic [15:0] a, input logic [7:0] x, input logic c);
        wr_en = 1'b0;
        req_valid = 1'b1;
        mode = eagen_pkg::eagen_mode_t'(m);
        ctr_r = a;
        idx_r = x;
        branch_cond = c;
        @(posedge mclk) #1;
    endtask
    task automatic op(input logic [3:0] m, input logic [15:0] a, input logic [23:0] d, input logic [7:0] x,
        input logic c);
        load(a, d);
        issue(m, a, x, c);
    endtask
    always @(posedge mclk) begin
        pend <= req_valid;
        exp_r <= f_exp(mode, req, branch_cond);
        exp_m <= mode;
    end
    always @(negedge mclk) begin
        check(16'(resp_valid), 16'(pend));
        if (pend) begin
            if (exp_m != eagen_pkg::MODE_REL) begin
                check(16'(resp.addr_high), 16'(exp_r.addr_high));
                check(16'(resp.addr_low), 16'(exp_r.addr_low));
            end
            check(resp.next_pc, exp_r.next_pc);
            if (exp_m >= eagen_pkg::MODE_BSC)
                check(16'(resp.bit_select), 16'(exp_r.bit_select));
        end
    end
    initial begin
        #200000;
        failures++;
        end_of_test();
    end
    initial begin
        resetn = 1'b0;
        req_valid = 1'b0;
        branch_cond = 1'b0;
        wr_en = 1'b0;
        mode = eagen_pkg::MODE_INH;
        ctr_r = 16'h0000;
        idx_r = 8'h00;
        wr_addr = 16'h0000;
        wr_data = 24'h000000;
        seed = $urandom(32'h7EE605B0);
        repeat (5) @(posedge mclk);
        #1 resetn = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        // carry and wrap corners, branch span limits
        op(eagen_pkg::MODE_IX1, 16'h1234, 24'hE6FF00, 8'hFF, 1'b0);
        op(eagen_pkg::MODE_IX2, 16'h2000, 24'hD6FF80, 8'h80, 1'b0);
        op(eagen_pkg::MODE_REL, 16'h3000, 24'h208000, 8'h11, 1'b1);
        op(eagen_pkg::MODE_REL, 16'h3000, 24'h207F00, 8'h11, 1'b1);
        op(eagen_pkg::MODE_REL, 16'h3000, 24'h207F00, 8'h11, 1'b0);
        op(eagen_pkg::MODE_BTB, 16'hFFFE, 24'h0F1080, 8'h22, 1'b1);
        op(eagen_pkg::MODE_BSC, 16'h4000, 24'h1E3300, 8'h22, 1'b0);
        for (int i = 0; i < 300; i++) begin
            ctr_r = 16'($urandom);
            load(ctr_r, 24'($urandom));
            load(ctr_r ^ 16'h8000, 24'($urandom));
            issue(4'($urandom % 10), ctr_r, 8'($urandom), 1'($urandom));
            issue(4'($urandom % 10), ctr_r ^ 16'h8000, 8'($urandom), 1'($urandom));
        end
        // mid-run reset clears the response, then requests resume
        req_valid = 1'b0;
        @(posedge mclk) #1;
        resetn = 1'b0;
        @(posedge mclk) #1;
        check({resp.addr_high, resp.addr_low}, 16'h0000);
        check(resp.next_pc, 16'h0000);
        check(16'(resp.bit_select), 16'h0000);
        check(16'(resp_valid), 16'h0000);
        repeat (4) @(posedge mclk);
        #1 resetn = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        op(eagen_pkg::MODE_EXT, 16'hFFFF, 24'hC61234, 8'h00, 1'b0);
        op(eagen_pkg::MODE_IMM, 16'hFFFF, 24'hA655AA, 8'h00, 1'b0);
        req_valid = 1'b0;
        repeat (2) @(posedge mclk);
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
